// *** design/dac_pkg.sv ***
// package of the two-channel 8-bit converter control block
// assumes a 20-bit byte address bus and 8-bit register data
package dac_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam logic [19:0] ADDR_CODE_CH0 = 20'hFFF9C;
  localparam logic [19:0] ADDR_CODE_CH1 = 20'hFFF9D;
  localparam logic [19:0] ADDR_CONV_CTRL = 20'hFFF9E;
  localparam logic [19:0] ADDR_STBY_CTRL = 20'hEE01A;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CODE = 8'h00;
  localparam logic [7:0] RST_CONV_CTRL = 8'h1F;
  localparam logic [7:0] RST_STBY_CTRL = 8'hFE;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ==========================================================
  // field positions
  localparam int BIT_CH1_OE = 7;
  localparam int BIT_CH0_OE = 6;
  localparam int BIT_JOINT = 5;
  localparam int BIT_KEEP = 0;
  localparam logic [7:0] CONV_RSVD_MASK = 8'h1F;
  localparam logic [7:0] STBY_RSVD_MASK = 8'hFE;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic ch1_oe;
    logic ch0_oe;
    logic joint;
  } dac_ctrl_type;

  typedef struct packed {
    logic conv_en;
    logic out_en;
    logic [7:0] code;
  } dac_chan_type;

endpackage

// *** design/dac_code_reg.sv ***
// one 8-bit channel code register
// assumes clear and write are decided by the caller
`timescale 1ns/10ps
module dac_code_reg (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] code_q
);

  // ==========================================================
  // storage; clear wins over a write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= dac_pkg::RST_CODE;
    end else if (clk_en) begin
      if (clear) begin
        code_q <= dac_pkg::RST_CODE;
      end else if (wr_en) begin
        code_q <= wdata;
      end
    end
  end

endmodule

// *** design/dac_enable_dec.sv ***
// decode of conversion and output enables from control fields
// purely combinational, outputs follow the inputs in the same cycle without a clock
`timescale 1ns/10ps
module dac_enable_dec (
  input dac_pkg::dac_ctrl_type ctrl,
  input wire logic out_allow,
  output logic conv0,
  output logic conv1,
  output logic oe0,
  output logic oe1
);

  // ==========================================================
  // decode
  always_comb begin
    conv0 = ctrl.ch0_oe | (ctrl.ch1_oe & ctrl.joint);
    conv1 = ctrl.ch1_oe | (ctrl.ch0_oe & ctrl.joint);
    oe0 = ctrl.ch0_oe & out_allow;
    oe1 = ctrl.ch1_oe & out_allow;
  end

endmodule

// *** design/dac_control.sv ***
// control logic of a two-channel 8-bit digital-to-analog converter
// assumes a plain register port and standby levels from the system
// What this block does
// - two 8-bit read/write channel code registers
// - enabled channel continuously presents its code
// - code registers clear on reset and standby
// - keep bit preserves codes through software standby
// - control register loads 0x1F on reset, standby
// - keep bit preserves control through software standby
// - bit 7 enables channel 1 conversion, output
// - bit 6 enables channel 0 conversion, output
// - bit 5 selects joint conversion control
// - pin drive follows own output enable, masked in hardware standby and in software standby without keep
// - both enables low disables all conversion
// - ch0 only, joint off: convert ch0 only
// - ch0 only, joint on: convert both
// - ch1 only, joint off: convert ch1 only
// - ch1 with joint or ch0: convert both
// - control bits 4..0 read one, not writable
// - standby bit 0 keeps output, resets zero
// - rewriting a code converts new value at once
`timescale 1ns/10ps
module dac_control (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata_q,
  input wire logic soft_standby,
  input wire logic hw_standby,
  output dac_pkg::dac_chan_type analog_out_ch0,
  output dac_pkg::dac_chan_type analog_out_ch1
);

  // ==========================================================
  // declarations
  logic soft_standby_q;
  logic standby_entry;
  logic keep_q;
  logic clear_regs;
  logic bus_ok;
  logic wr_code0;
  logic wr_code1;
  logic [7:0] code0_q;
  logic [7:0] code1_q;
  dac_pkg::dac_ctrl_type ctrl_q;
  logic out_allow;
  logic conv0;
  logic conv1;
  logic oe0;
  logic oe1;
  logic [7:0] rd_mux;

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [19:0] a,
                               input logic [19:0] base);
    hit = (a == base);
  endfunction

  function automatic dac_pkg::dac_ctrl_type ctrl_of(input logic [7:0] v);
    ctrl_of.ch1_oe = v[dac_pkg::BIT_CH1_OE];
    ctrl_of.ch0_oe = v[dac_pkg::BIT_CH0_OE];
    ctrl_of.joint = v[dac_pkg::BIT_JOINT];
  endfunction

  // ==========================================================
  // standby tracking
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      soft_standby_q <= 1'b0;
    end else if (clk_en) begin
      soft_standby_q <= soft_standby;
    end
  end

  assign standby_entry = soft_standby & ~soft_standby_q;
  // hardware standby always clears; software standby only without keep
  assign clear_regs = hw_standby | (standby_entry & ~keep_q);
  assign bus_ok = ~hw_standby & ~soft_standby;
  assign wr_code0 = wr_stb & bus_ok & hit(addr, dac_pkg::ADDR_CODE_CH0);
  assign wr_code1 = wr_stb & bus_ok & hit(addr, dac_pkg::ADDR_CODE_CH1);

  // ==========================================================
  // standby control register, keep bit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      keep_q <= dac_pkg::RST_STBY_CTRL[dac_pkg::BIT_KEEP];
    end else if (clk_en) begin
      if (hw_standby) begin
        keep_q <= dac_pkg::RST_STBY_CTRL[dac_pkg::BIT_KEEP];
      end else if (wr_stb & bus_ok &
                   hit(addr, dac_pkg::ADDR_STBY_CTRL)) begin
        keep_q <= wdata[dac_pkg::BIT_KEEP];
      end
    end
  end

  // ==========================================================
  // converter control register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= ctrl_of(dac_pkg::RST_CONV_CTRL);
    end else if (clk_en) begin
      if (clear_regs) begin
        ctrl_q <= ctrl_of(dac_pkg::RST_CONV_CTRL);
      end else if (wr_stb & bus_ok &
                   hit(addr, dac_pkg::ADDR_CONV_CTRL)) begin
        ctrl_q <= ctrl_of(wdata);
      end
    end
  end

  // ==========================================================
  // channel code registers
  dac_code_reg u_code0 (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .clear(clear_regs),
    .wr_en(wr_code0),
    .wdata(wdata),
    .code_q(code0_q)
  );

  dac_code_reg u_code1 (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .clear(clear_regs),
    .wr_en(wr_code1),
    .wdata(wdata),
    .code_q(code1_q)
  );

  // ==========================================================
  // enable decode and channel outputs
  assign out_allow = ~hw_standby & (~soft_standby | keep_q);

  dac_enable_dec u_dec (
    .ctrl(ctrl_q),
    .out_allow(out_allow),
    .conv0(conv0),
    .conv1(conv1),
    .oe0(oe0),
    .oe1(oe1)
  );

  always_comb begin
    analog_out_ch0.conv_en = conv0;
    analog_out_ch0.out_en = oe0;
    analog_out_ch0.code = code0_q;
    analog_out_ch1.conv_en = conv1;
    analog_out_ch1.out_en = oe1;
    analog_out_ch1.code = code1_q;
  end

  // ==========================================================
  // read path, data valid only in the cycle after the strobe
  always_comb begin
    rd_mux = dac_pkg::RD_UNMAPPED;
    if (hit(addr, dac_pkg::ADDR_CODE_CH0)) begin
      rd_mux = code0_q;
    end else if (hit(addr, dac_pkg::ADDR_CODE_CH1)) begin
      rd_mux = code1_q;
    end else if (hit(addr, dac_pkg::ADDR_CONV_CTRL)) begin
      rd_mux = dac_pkg::CONV_RSVD_MASK;
      rd_mux[dac_pkg::BIT_CH1_OE] = ctrl_q.ch1_oe;
      rd_mux[dac_pkg::BIT_CH0_OE] = ctrl_q.ch0_oe;
      rd_mux[dac_pkg::BIT_JOINT] = ctrl_q.joint;
    end else if (hit(addr, dac_pkg::ADDR_STBY_CTRL)) begin
      rd_mux = dac_pkg::STBY_RSVD_MASK;
      rd_mux[dac_pkg::BIT_KEEP] = keep_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= dac_pkg::RD_UNMAPPED;
    end else if (clk_en) begin
      rdata_q <= rd_stb ? rd_mux : dac_pkg::RD_UNMAPPED;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_code_write_lands: assert property (
    clk_en && wr_code0 && !clear_regs |=> code0_q == $past(wdata))
    else $error("channel 0 code write not stored");

  a_code_readback: assert property (
    clk_en && rd_stb && hit(addr, dac_pkg::ADDR_CODE_CH1)
    |=> rdata_q == $past(code1_q))
    else $error("channel 1 code read back wrong");

  a_code_presented: assert property (
    analog_out_ch0.out_en
    |-> analog_out_ch0.conv_en && analog_out_ch0.code == code0_q)
    else $error("enabled channel 0 not converting its code");

  a_hw_stby_clear: assert property (
    clk_en && hw_standby |=> code0_q == dac_pkg::RST_CODE
      && code1_q == dac_pkg::RST_CODE)
    else $error("codes not cleared in hardware standby");

  a_keep_holds_code: assert property (
    clk_en && standby_entry && keep_q && !hw_standby && !wr_code1
    |=> $stable(code1_q))
    else $error("code lost through kept software standby");

  a_ctrl_stby_init: assert property (
    clk_en && standby_entry && !keep_q
    |=> ctrl_q == ctrl_of(dac_pkg::RST_CONV_CTRL))
    else $error("control register not reinitialised on standby");

  a_keep_holds_ctrl: assert property (
    clk_en && soft_standby && keep_q && !hw_standby
    |=> $stable(ctrl_q))
    else $error("control changed in kept software standby");

  a_both_off: assert property (
    !ctrl_q.ch0_oe && !ctrl_q.ch1_oe
    |-> !analog_out_ch0.conv_en && !analog_out_ch1.conv_en)
    else $error("conversion running with both enables low");

  a_joint_both_run: assert property (
    ctrl_q.ch0_oe && ctrl_q.joint
    |-> analog_out_ch0.conv_en && analog_out_ch1.conv_en)
    else $error("joint conversion did not run both channels");

  a_single_ch1: assert property (
    ctrl_q.ch1_oe && !ctrl_q.ch0_oe && !ctrl_q.joint
    |-> analog_out_ch1.conv_en && !analog_out_ch0.conv_en)
    else $error("channel 1 only mode converts wrong channels");

  a_pin_own_enable: assert property (
    out_allow |-> analog_out_ch1.out_en == ctrl_q.ch1_oe
      && analog_out_ch0.out_en == ctrl_q.ch0_oe)
    else $error("pin drive not following own enable");

  a_ctrl_rsvd_ones: assert property (
    clk_en && rd_stb && hit(addr, dac_pkg::ADDR_CONV_CTRL)
    |=> (rdata_q & dac_pkg::CONV_RSVD_MASK) == dac_pkg::CONV_RSVD_MASK)
    else $error("reserved control bits not read as one");

  a_stby_out_off: assert property (
    soft_standby && !keep_q
    |-> !analog_out_ch0.out_en && !analog_out_ch1.out_en)
    else $error("output driven in standby without keep");

  a_enable_next_clk: assert property (
    clk_en && !clear_regs && wr_stb && bus_ok
      && hit(addr, dac_pkg::ADDR_CONV_CTRL)
    |=> analog_out_ch0.conv_en == ($past(wdata[dac_pkg::BIT_CH0_OE])
      | ($past(wdata[dac_pkg::BIT_CH1_OE])
      & $past(wdata[dac_pkg::BIT_JOINT]))))
    else $error("enable decode late or wrong after control write");

  a_ch1_oe_field: assert property (
    clk_en && wr_stb && bus_ok && !clear_regs
      && hit(addr, dac_pkg::ADDR_CONV_CTRL)
    |=> ctrl_q.ch1_oe == $past(wdata[dac_pkg::BIT_CH1_OE]))
    else $error("channel 1 output enable not stored");

  a_ch0_oe_field: assert property (
    clk_en && wr_stb && bus_ok && !clear_regs
      && hit(addr, dac_pkg::ADDR_CONV_CTRL)
    |=> ctrl_q.ch0_oe == $past(wdata[dac_pkg::BIT_CH0_OE]))
    else $error("channel 0 output enable not stored");

  a_joint_field: assert property (
    clk_en && wr_stb && bus_ok && !clear_regs
      && hit(addr, dac_pkg::ADDR_CONV_CTRL)
    |=> ctrl_q.joint == $past(wdata[dac_pkg::BIT_JOINT]))
    else $error("joint conversion enable not stored");

  a_single_ch0: assert property (
    ctrl_q.ch0_oe && !ctrl_q.ch1_oe && !ctrl_q.joint
    |-> analog_out_ch0.conv_en && !analog_out_ch1.conv_en)
    else $error("channel 0 only mode converts wrong channels");

  a_ch1_pair_both: assert property (
    ctrl_q.ch1_oe && (ctrl_q.joint || ctrl_q.ch0_oe)
    |-> analog_out_ch0.conv_en && analog_out_ch1.conv_en)
    else $error("channel 1 pairing did not run both channels");

  a_code_rewrite: assert property (
    clk_en && wr_code1 && !clear_regs
    |=> analog_out_ch1.code == $past(wdata))
    else $error("rewritten channel 1 code not presented");

  a_ch1_presented: assert property (
    analog_out_ch1.out_en
    |-> analog_out_ch1.conv_en && analog_out_ch1.code == code1_q)
    else $error("enabled channel 1 not converting its code");

  a_soft_stby_clear: assert property (
    clk_en && standby_entry && !keep_q
    |=> code0_q == dac_pkg::RST_CODE
      && code1_q == dac_pkg::RST_CODE)
    else $error("codes not cleared on standby entry");

  a_keep_codes_stay: assert property (
    clk_en && soft_standby && keep_q && !hw_standby
    |=> $stable(code0_q) && $stable(code1_q))
    else $error("code changed in kept software standby");

  a_ctrl_hw_clear: assert property (
    clk_en && hw_standby
    |=> ctrl_q == ctrl_of(dac_pkg::RST_CONV_CTRL))
    else $error("control register not reinitialised in hardware standby");

  a_stby_readback: assert property (
    clk_en && rd_stb && hit(addr, dac_pkg::ADDR_STBY_CTRL)
    |=> rdata_q == (dac_pkg::STBY_RSVD_MASK | {7'h00, $past(keep_q)}))
    else $error("standby register read back wrong");

  a_hw_resets_keep: assert property (
    clk_en && hw_standby |=> !keep_q)
    else $error("keep bit survived hardware standby");

  a_freeze_state: assert property (
    !clk_en |=> $stable(code0_q) && $stable(code1_q) && $stable(ctrl_q))
    else $error("state changed while clock enable low");

  // ==========================================================
  // cover of the main scenarios
  c_single_ch1_run: cover property (
    ctrl_q.ch1_oe && !ctrl_q.ch0_oe && !ctrl_q.joint);
  c_joint_mode: cover property (
    ctrl_q.ch0_oe && !ctrl_q.ch1_oe && ctrl_q.joint);
  c_kept_standby: cover property (
    standby_entry && keep_q && analog_out_ch0.out_en);
  c_rewrite_enabled: cover property (
    analog_out_ch1.out_en && wr_code1 && clk_en);
  c_hw_standby: cover property (hw_standby && clk_en);

endmodule

// *** testbench/dac_analog_model.sv ***
// behavioural model of one analog conversion channel and its output pin
// assumes the channel carrier of the converter control block
`timescale 1ns/10ps
module dac_analog_model #(
  parameter int CONV_CYCLES = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input dac_pkg::dac_chan_type chan,
  output logic [7:0] pin
);
  // ==========================================================
  // conversion delay and settled level
  logic [7:0] last_code_q;
  logic [7:0] level_q;
  int count_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= CONV_CYCLES;
      last_code_q <= 8'h00;
      level_q <= 8'h00;
    end else begin
      last_code_q <= chan.code;
      if (!chan.conv_en) begin
        count_q <= CONV_CYCLES;
      end else if (chan.code != last_code_q) begin
        count_q <= CONV_CYCLES;
      end else if (count_q > 0) begin
        count_q <= count_q - 1;
      end
      if (chan.conv_en && count_q == 1) begin
        level_q <= chan.code;
      end
    end
  end

  // a released pin shows the inverted settled level
  assign pin = chan.out_en ? level_q : ~level_q;
endmodule

// *** testbench/dac_control_bench.sv ***
// self-checking bench of the converter control block
// assumes the analog channel model beside it; the bench drives clock enable
`timescale 1ns/10ps
module dac_control_bench;
  logic clock, rst_n, clk_en, wr_stb, rd_stb, soft_standby, hw_standby;
  logic [19:0] addr;
  logic [7:0] wdata, rdata_q, pin0, pin1;
  dac_pkg::dac_chan_type ch0, ch1;
  int err_total, check_count;

  dac_control i_dac_control (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata_q(rdata_q), .soft_standby(soft_standby),
    .hw_standby(hw_standby), .analog_out_ch0(ch0), .analog_out_ch1(ch1));
  dac_analog_model i_dac_analog_model_ch0 (.clock(clock), .rst_n(rst_n),
    .chan(ch0), .pin(pin0));
  dac_analog_model i_dac_analog_model_ch1 (.clock(clock), .rst_n(rst_n),
    .chan(ch1), .pin(pin1));

  // ==========================================================
  // bus and compare tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    chk(rdata_q, exp, "read");
  endtask

  task automatic close_out;
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic reset_values;
    rd(dac_pkg::ADDR_CODE_CH0, 8'h00);
    rd(dac_pkg::ADDR_CODE_CH1, 8'h00);
    rd(dac_pkg::ADDR_CONV_CTRL, 8'h1F);
    rd(dac_pkg::ADDR_STBY_CTRL, 8'hFE);
    rd(20'h00000, 8'h00);
  endtask

  task automatic decode_table;
    logic [2:0] b;
    logic e0;
    logic e1;
    for (int i = 0; i < 8; i++) begin
      b = i[2:0];
      e0 = b[1] | (b[2] & b[0]);
      e1 = b[2] | (b[1] & b[0]);
      wr(dac_pkg::ADDR_CONV_CTRL, {b, 5'h00});
      @(negedge clock);
      chk({7'h00, ch0.conv_en}, {7'h00, e0}, "conv0");
      chk({7'h00, ch1.conv_en}, {7'h00, e1}, "conv1");
      chk({7'h00, ch0.out_en}, {7'h00, b[1]}, "oe0");
      chk({7'h00, ch1.out_en}, {7'h00, b[2]}, "oe1");
      rd(dac_pkg::ADDR_CONV_CTRL, {b, 5'h1F});
    end
  endtask

  task automatic codes_and_pins;
    wr(dac_pkg::ADDR_CONV_CTRL, 8'hC0);
    wr(dac_pkg::ADDR_CODE_CH0, 8'hA5);
    @(negedge clock);
    chk(ch0.code, 8'hA5, "code0");
    wr(dac_pkg::ADDR_CODE_CH1, 8'h5A);
    rd(dac_pkg::ADDR_CODE_CH0, 8'hA5);
    rd(dac_pkg::ADDR_CODE_CH1, 8'h5A);
    repeat (6) @(negedge clock);
    chk(pin0, 8'hA5, "pin0");
    chk(pin1, 8'h5A, "pin1");
  endtask

  task automatic standby(input logic keep);
    wr(dac_pkg::ADDR_STBY_CTRL, {7'h00, keep});
    wr(dac_pkg::ADDR_CONV_CTRL, 8'hC0);
    wr(dac_pkg::ADDR_CODE_CH0, 8'h3C);
    @(posedge clock);
    soft_standby <= 1'b1;
    wr(dac_pkg::ADDR_CODE_CH0, 8'hFF);
    @(negedge clock);
    chk({7'h00, ch0.out_en}, {7'h00, keep}, "standby oe");
    @(posedge clock);
    soft_standby <= 1'b0;
    rd(dac_pkg::ADDR_CODE_CH0, keep ? 8'h3C : 8'h00);
    rd(dac_pkg::ADDR_CONV_CTRL, keep ? 8'hDF : 8'h1F);
    rd(dac_pkg::ADDR_STBY_CTRL, {7'h7F, keep});
  endtask

  task automatic hw_reset;
    wr(dac_pkg::ADDR_STBY_CTRL, 8'h01);
    wr(dac_pkg::ADDR_CODE_CH1, 8'h77);
    @(posedge clock);
    hw_standby <= 1'b1;
    repeat (2) @(posedge clock);
    hw_standby <= 1'b0;
    rd(dac_pkg::ADDR_STBY_CTRL, 8'hFE);
    rd(dac_pkg::ADDR_CODE_CH1, 8'h00);
    rd(dac_pkg::ADDR_CONV_CTRL, 8'h1F);
  endtask

  task automatic freeze;
    wr(dac_pkg::ADDR_CODE_CH0, 8'h6B);
    @(posedge clock);
    clk_en <= 1'b0;
    wr(dac_pkg::ADDR_CODE_CH0, 8'h94);
    @(posedge clock);
    clk_en <= 1'b1;
    rd(dac_pkg::ADDR_CODE_CH0, 8'h6B);
  endtask

  task automatic mid_reset;
    wr(dac_pkg::ADDR_CODE_CH1, 8'h33);
    wr(dac_pkg::ADDR_STBY_CTRL, 8'h01);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(dac_pkg::ADDR_CODE_CH1, 8'h00);
    rd(dac_pkg::ADDR_STBY_CTRL, 8'hFE);
    rd(dac_pkg::ADDR_CONV_CTRL, 8'h1F);
  endtask

  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    close_out();
  end

  initial begin
    err_total = 0;
    check_count = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    soft_standby = 1'b0;
    hw_standby = 1'b0;
    addr = 20'h00000;
    wdata = 8'h00;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    reset_values();
    decode_table();
    codes_and_pins();
    freeze();
    standby(1'b0);
    standby(1'b1);
    hw_reset();
    mid_reset();
    close_out();
  end
endmodule
